// ---- shared/fll_regs.svh ----
`ifndef FLL_REGS_SVH
`define FLL_REGS_SVH

// Register addresses on the plain register port.
`define ADDR_LOOP_CONTROL 16'h0191
`define ADDR_LOOP_UPDATE 16'h0192
`define ADDR_REF_DETECT 16'h0196
`define ADDR_DETECTOR_GAINS 16'h0198
`define ADDR_FRACTION_MODE 16'h019A
`define ADDR_LOCK_DETECT 16'h019B
`define ADDR_OSC_RANGE 16'h019D
`define ADDR_LOOP_STATUS 16'h01A0
`define ADDR_GPIO_SELECT 16'h01A2

// Field positions.
`define PD_FINE_MSB 15
`define PD_FINE_LSB 12
`define PD_COARSE_MSB 11
`define PD_COARSE_LSB 8
`define FD_FINE_MSB 7
`define FD_FINE_LSB 4
`define FD_COARSE_MSB 3
`define FD_COARSE_LSB 0
`define FRAC_SEL_MSB 15
`define FRAC_SEL_LSB 14
`define LOCK_THR_MSB 4
`define LOCK_THR_LSB 1
`define LOCK_ENA_BIT 0
`define RANGE_MSB 1
`define RANGE_LSB 0
`define APPLY_BIT 15
`define REF_ENA_BIT 15
`define LOOP_ENA_BIT 0
`define GPIO_LOCK_BIT 0
`define GPIO_CLK_BIT 1

// Reset values, and the fractional mode and reserved fine frequency codes.
`define GAINS_RESET 16'h21F0
`define FRAC_SEL_RESET 2'h0
`define FRAC_SEL_FRACTIONAL 2'h3
`define LOCK_THR_RESET 4'h8
`define LOCK_ENA_RESET 1'h1
`define RANGE_RESET 2'h0
`define REF_ENA_RESET 1'h1
`define LOOP_ENA_RESET 1'h0
`define GPIO_SEL_RESET 2'h0
`define FD_FINE_RESERVED 4'hF

// Timing.
`define CLK_PERIOD_PS 5000
`define DEBOUNCE_NS 100
`define DEBOUNCE_CYCLES ((`DEBOUNCE_NS * 1000) / `CLK_PERIOD_PS)
`define REF_TIMEOUT_NS 2000
`define REF_TIMEOUT_CYCLES ((`REF_TIMEOUT_NS * 1000) / `CLK_PERIOD_PS)

`endif

// ---- shared/fll_pkg.sv ----
package fll_pkg;

  typedef logic [15:0] word_t;

  typedef struct packed {
    logic [3:0] pd_fine;
    logic [3:0] pd_coarse;
    logic [3:0] fd_fine;
    logic [3:0] fd_coarse;
    logic [1:0] frac_sel;
    logic [1:0] osc_range;
  } loop_cfg_s;

  typedef enum logic {REF_ABSENT, REF_PRESENT} ref_state_e;

  // Returns X of gain 2^-X; signed fields are two's complement.
  function automatic logic signed [4:0] gain_exponent(input logic [3:0] code,
                                                      input logic is_signed);
    gain_exponent = is_signed ? {code[3], code} : {1'b0, code};
  endfunction

endpackage

// ---- shared/status_if.sv ----
`timescale 1ns/1ps
interface status_if;
  logic lock_raw;
  logic ref_raw;
  logic clock_running;
  logic ack_lock;
  logic ack_ref;
  logic lock_deb;
  logic ref_deb;
  logic lock_event;
  logic ref_event;

  modport filter (
    input lock_raw, ref_raw, clock_running, ack_lock, ack_ref,
    output lock_deb, ref_deb, lock_event, ref_event
  );
  modport owner (
    output lock_raw, ref_raw, clock_running, ack_lock, ack_ref,
    input lock_deb, ref_deb, lock_event, ref_event
  );
endinterface

// ---- core/status_debounce.sv ----
`timescale 1ns/1ps
`include "fll_regs.svh"
module status_debounce (
  input wire logic mclk, // Clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  status_if.filter st // Status signals in and out.
);

  localparam logic [15:0] DEB_LAST = 16'(`DEBOUNCE_CYCLES - 1);

  logic [15:0] lock_cnt_r;
  logic [15:0] ref_cnt_r;
  logic lock_deb_r;
  logic ref_deb_r;
  logic lock_evt_r;
  logic ref_evt_r;

  // A new level is taken only after it stood for the full debounce time, and the
  // count advances only while a status clock is running.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lock_cnt_r <= 16'h0000;
      lock_deb_r <= 1'b0;
    end else if (st.lock_raw == lock_deb_r) begin
      lock_cnt_r <= 16'h0000;
    end else if (st.clock_running) begin
      if (lock_cnt_r == DEB_LAST) begin
        lock_deb_r <= st.lock_raw;
        lock_cnt_r <= 16'h0000;
      end else begin
        lock_cnt_r <= lock_cnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ref_cnt_r <= 16'h0000;
      ref_deb_r <= 1'b0;
    end else if (st.ref_raw == ref_deb_r) begin
      ref_cnt_r <= 16'h0000;
    end else if (st.clock_running) begin
      if (ref_cnt_r == DEB_LAST) begin
        ref_deb_r <= st.ref_raw;
        ref_cnt_r <= 16'h0000;
      end else begin
        ref_cnt_r <= ref_cnt_r + 16'h0001;
      end
    end
  end

  // Pending events; a new lock change or reference stop in the acknowledge cycle keeps its event set.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lock_evt_r <= 1'b0;
    end else if (st.clock_running && lock_cnt_r == DEB_LAST && st.lock_raw != lock_deb_r) begin
      lock_evt_r <= 1'b1;
    end else if (st.ack_lock) begin
      lock_evt_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ref_evt_r <= 1'b0;
    end else if (st.clock_running && ref_cnt_r == DEB_LAST && ref_deb_r && !st.ref_raw) begin
      ref_evt_r <= 1'b1;
    end else if (st.ack_ref) begin
      ref_evt_r <= 1'b0;
    end
  end

  assign st.lock_deb = lock_deb_r;
  assign st.ref_deb = ref_deb_r;
  assign st.lock_event = lock_evt_r;
  assign st.ref_event = ref_evt_r;

endmodule // status_debounce

// ---- core/fll_cfg_status.sv ----
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`include "fll_regs.svh"
module fll_cfg_status (
  input wire logic mclk, // Clock, 200 MHz.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic [15:0] reg_addr, // Register address.
  input wire logic [15:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  output logic [15:0] reg_rdata, // Read data, cycle after the strobe.
  input wire logic [7:0] phase_error, // Loop phase error magnitude.
  input wire logic ref_clk_level, // Sampled reference clock level.
  input wire logic slow_clk_running, // 32 kHz status clock running.
  input wire logic system_clock_running, // System clock running.
  input wire logic ack_lock, // Interrupt controller ack, lock event.
  input wire logic ack_ref, // Interrupt controller ack, reference event.
  output logic loop_enable, // Loop enable.
  output logic signed [4:0] phase_detector_fine_gain, // Applied exponent X.
  output logic signed [4:0] phase_detector_coarse_gain, // Applied exponent X.
  output logic signed [4:0] frequency_detector_fine_gain, // Applied exponent X.
  output logic signed [4:0] frequency_detector_coarse_gain, // Applied exponent X.
  output logic fd_fine_reserved, // Applied fine frequency code is reserved.
  output logic loop_fraction_select, // Applied: 1 fractional, 0 integer.
  output logic [1:0] oscillator_range_select, // Applied oscillator range.
  output logic lock_status, // Debounced lock status.
  output logic ref_present, // Debounced reference present.
  output logic lock_event, // Pending lock change event.
  output logic ref_stop_event, // Pending reference stop event.
  output logic gpio_lock, // Undebounced lock on GPIO.
  output logic gpio_clk // Clock on GPIO, mclk divided by two.
);

  localparam logic [15:0] REF_LAST = 16'(`REF_TIMEOUT_CYCLES - 1);

  fll_pkg::loop_cfg_s staged_r;
  fll_pkg::loop_cfg_s applied_r;
  logic loop_ena_r;
  logic [3:0] lock_thr_r;
  logic lock_ena_r;
  logic ref_ena_r;
  logic [1:0] gpio_sel_r;
  logic lock_ind_r;
  logic gpio_lock_r;
  logic gpio_clk_r;
  logic ref_level_r;
  logic [15:0] ref_timer_r;
  fll_pkg::ref_state_e ref_state_r;
  logic ref_ind_r;
  fll_pkg::word_t rdata_r;
  logic wr_gains;
  logic wr_mode;
  logic wr_range;
  logic apply;

  status_if st ();

  assign wr_gains = reg_wr && reg_addr == `ADDR_DETECTOR_GAINS;
  assign wr_mode = reg_wr && reg_addr == `ADDR_FRACTION_MODE;
  assign wr_range = reg_wr && reg_addr == `ADDR_OSC_RANGE;
  assign apply = reg_wr && reg_addr == `ADDR_LOOP_UPDATE && reg_wdata[`APPLY_BIT]
                 && loop_ena_r;

  // Staged loop configuration written by software.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      staged_r <= '{pd_fine: 4'(`GAINS_RESET >> `PD_FINE_LSB),
                    pd_coarse: 4'(`GAINS_RESET >> `PD_COARSE_LSB),
                    fd_fine: 4'(`GAINS_RESET >> `FD_FINE_LSB),
                    fd_coarse: 4'(`GAINS_RESET >> `FD_COARSE_LSB),
                    frac_sel: `FRAC_SEL_RESET,
                    osc_range: `RANGE_RESET};
    end else begin
      if (wr_gains) begin
        staged_r.pd_fine <= reg_wdata[`PD_FINE_MSB:`PD_FINE_LSB];
        staged_r.pd_coarse <= reg_wdata[`PD_COARSE_MSB:`PD_COARSE_LSB];
        staged_r.fd_fine <= reg_wdata[`FD_FINE_MSB:`FD_FINE_LSB];
        staged_r.fd_coarse <= reg_wdata[`FD_COARSE_MSB:`FD_COARSE_LSB];
      end
      if (wr_mode) begin
        staged_r.frac_sel <= reg_wdata[`FRAC_SEL_MSB:`FRAC_SEL_LSB];
      end
      if (wr_range) begin
        staged_r.osc_range <= reg_wdata[`RANGE_MSB:`RANGE_LSB];
      end
    end
  end

  // The loop only sees a new configuration on an update while enabled.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      applied_r <= '{pd_fine: 4'(`GAINS_RESET >> `PD_FINE_LSB),
                     pd_coarse: 4'(`GAINS_RESET >> `PD_COARSE_LSB),
                     fd_fine: 4'(`GAINS_RESET >> `FD_FINE_LSB),
                     fd_coarse: 4'(`GAINS_RESET >> `FD_COARSE_LSB),
                     frac_sel: `FRAC_SEL_RESET,
                     osc_range: `RANGE_RESET};
    end else if (apply) begin
      applied_r <= staged_r;
    end
  end

  // Lock and reference detect controls act at once; they touch no loop setting.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      loop_ena_r <= `LOOP_ENA_RESET;
      lock_thr_r <= `LOCK_THR_RESET;
      lock_ena_r <= `LOCK_ENA_RESET;
      ref_ena_r <= `REF_ENA_RESET;
      gpio_sel_r <= `GPIO_SEL_RESET;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `ADDR_LOOP_CONTROL: loop_ena_r <= reg_wdata[`LOOP_ENA_BIT];
        `ADDR_LOCK_DETECT: begin
          lock_thr_r <= reg_wdata[`LOCK_THR_MSB:`LOCK_THR_LSB];
          lock_ena_r <= reg_wdata[`LOCK_ENA_BIT];
        end
        `ADDR_REF_DETECT: ref_ena_r <= reg_wdata[`REF_ENA_BIT];
        `ADDR_GPIO_SELECT: gpio_sel_r <= reg_wdata[`GPIO_CLK_BIT:`GPIO_LOCK_BIT];
        default: ;
      endcase
    end
  end

  // Lock when the phase error is within the threshold window; 0x0 is tightest.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lock_ind_r <= 1'b0;
    end else begin
      lock_ind_r <= lock_ena_r && (phase_error <= {lock_thr_r, 4'hF});
    end
  end

  // Reference present while an edge arrives within the timeout.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ref_level_r <= 1'b0;
      ref_timer_r <= 16'h0000;
      ref_state_r <= fll_pkg::REF_ABSENT;
    end else begin
      ref_level_r <= ref_clk_level;
      if (ref_clk_level != ref_level_r) begin
        ref_timer_r <= 16'h0000;
        ref_state_r <= fll_pkg::REF_PRESENT;
      end else if (ref_timer_r == REF_LAST) begin
        ref_state_r <= fll_pkg::REF_ABSENT;
      end else begin
        ref_timer_r <= ref_timer_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ref_ind_r <= 1'b0;
    end else begin
      ref_ind_r <= ref_ena_r && ref_state_r == fll_pkg::REF_PRESENT;
    end
  end

  assign st.lock_raw = lock_ind_r;
  assign st.ref_raw = ref_ind_r;
  assign st.clock_running = slow_clk_running || system_clock_running;
  assign st.ack_lock = ack_lock;
  assign st.ack_ref = ack_ref;

  status_debounce u_debounce (
    .mclk(mclk),
    .reset_n(reset_n),
    .st(st.filter)
  );

  // The GPIO lock output bypasses the debounce; only one output flop is added.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      gpio_lock_r <= 1'b0;
      gpio_clk_r <= 1'b0;
    end else begin
      gpio_lock_r <= gpio_sel_r[`GPIO_LOCK_BIT] && lock_ind_r;
      gpio_clk_r <= gpio_sel_r[`GPIO_CLK_BIT] && !gpio_clk_r;
    end
  end

  // Register read port; unmapped addresses read zero.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `ADDR_LOOP_CONTROL: rdata_r <= {15'h0000, loop_ena_r};
        `ADDR_LOOP_UPDATE: rdata_r <= 16'h0000;
        `ADDR_REF_DETECT: rdata_r <= {ref_ena_r, 15'h0000};
        `ADDR_DETECTOR_GAINS: rdata_r <= {staged_r.pd_fine, staged_r.pd_coarse,
                                          staged_r.fd_fine, staged_r.fd_coarse};
        `ADDR_FRACTION_MODE: rdata_r <= {staged_r.frac_sel, 14'h0000};
        `ADDR_LOCK_DETECT: rdata_r <= {11'h000, lock_thr_r, lock_ena_r};
        `ADDR_OSC_RANGE: rdata_r <= {14'h0000, staged_r.osc_range};
        `ADDR_LOOP_STATUS: rdata_r <= {11'h000, lock_ind_r, st.ref_event, st.lock_event,
                                       st.ref_deb, st.lock_deb};
        `ADDR_GPIO_SELECT: rdata_r <= {14'h0000, gpio_sel_r};
        default: rdata_r <= 16'h0000;
      endcase
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  // Registered outputs of the applied configuration and the loop enable.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      phase_detector_fine_gain <= 5'h00;
      phase_detector_coarse_gain <= 5'h00;
      frequency_detector_fine_gain <= 5'h00;
      frequency_detector_coarse_gain <= 5'h00;
      fd_fine_reserved <= 1'b0;
      loop_fraction_select <= 1'b0;
      oscillator_range_select <= 2'h0;
      loop_enable <= 1'b0;
    end else begin
      phase_detector_fine_gain <= fll_pkg::gain_exponent(applied_r.pd_fine, 1'b1);
      phase_detector_coarse_gain <= fll_pkg::gain_exponent(applied_r.pd_coarse, 1'b1);
      frequency_detector_fine_gain <= fll_pkg::gain_exponent(applied_r.fd_fine, 1'b0);
      frequency_detector_coarse_gain <= fll_pkg::gain_exponent(applied_r.fd_coarse, 1'b1);
      fd_fine_reserved <= applied_r.fd_fine == `FD_FINE_RESERVED;
      loop_fraction_select <= applied_r.frac_sel == `FRAC_SEL_FRACTIONAL;
      oscillator_range_select <= applied_r.osc_range;
      loop_enable <= loop_ena_r;
    end
  end

  // Debounced status and pending events, registered once more for the ports.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lock_status <= 1'b0;
      ref_present <= 1'b0;
      lock_event <= 1'b0;
      ref_stop_event <= 1'b0;
    end else begin
      lock_status <= st.lock_deb;
      ref_present <= st.ref_deb;
      lock_event <= st.lock_event;
      ref_stop_event <= st.ref_event;
    end
  end

  assign reg_rdata = rdata_r;
  assign gpio_lock = gpio_lock_r;
  assign gpio_clk = gpio_clk_r;

endmodule // fll_cfg_status

// ---- bench/ref_source.sv ----
`timescale 1ns/1ps
module ref_source (
  input wire logic mclk, // Design clock that paces the reference.
  input wire logic run, // Reference toggles while high.
  output logic ref_clk_level // Reference clock level.
);
  logic [2:0] cnt_r = 3'h0;
  initial ref_clk_level = 1'b0;
  // A stopped reference holds its last level, as a dead oscillator does.
  always @(posedge mclk) begin
    if (run) begin
      cnt_r <= cnt_r + 3'h1;
      if (cnt_r == 3'h7) ref_clk_level <= ~ref_clk_level;
    end
  end
endmodule // ref_source

// ---- bench/fll_checker.sv ----
`timescale 1ns/1ps
`include "fll_regs.svh"
module fll_checker (
  input wire logic mclk, // Clock.
  input wire logic reset_n, // Reset, active low.
  input wire logic [15:0] reg_addr, // Address.
  input wire logic [15:0] reg_wdata, // Write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic slow_clk_running, // Slow clock on.
  input wire logic system_clock_running, // System clock on.
  input wire logic ack_lock, // Lock ack.
  input wire logic ack_ref, // Reference ack.
  input wire logic signed [4:0] phase_detector_fine_gain, // Applied exponent.
  input wire logic signed [4:0] frequency_detector_fine_gain, // Applied exponent.
  input wire logic fd_fine_reserved, // Reserved code flag.
  input wire logic loop_fraction_select, // Applied mode.
  input wire logic [1:0] oscillator_range_select, // Applied range.
  input wire logic lock_status, // Debounced lock.
  input wire logic ref_present, // Debounced reference.
  input wire logic lock_event, // Lock event.
  input wire logic ref_stop_event, // Reference event.
  input wire logic gpio_clk // Clock output.
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic [4:0] idle_r;
  logic [4:0] since_r;
  logic [2:0] apply_r;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) idle_r <= 5'h00;
    else if (slow_clk_running || system_clock_running) idle_r <= 5'h00;
    else if (idle_r != 5'h1F) idle_r <= idle_r + 5'h01;
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) since_r <= 5'h1F;
    else if ($changed(lock_status)) since_r <= 5'h01;
    else if (since_r != 5'h1F) since_r <= since_r + 5'h01;
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) apply_r <= 3'h0;
    else apply_r <= {apply_r[1:0], reg_wr && reg_addr == `ADDR_LOOP_UPDATE && reg_wdata[15]};
  end
  sequence s_pending(ev, ack);
    ev && !$past(ack);
  endsequence
  property p_apply_only;
    $past(reset_n, 2) && ($changed(phase_detector_fine_gain) || $changed(loop_fraction_select)
      || $changed(oscillator_range_select)) |-> apply_r != 3'h0;
  endproperty
  property p_fd_unsigned;
    !frequency_detector_fine_gain[4]
      && (fd_fine_reserved == (frequency_detector_fine_gain == 5'sd15));
  endproperty
  property p_lock_event;
    $changed(lock_status) |-> lock_event;
  endproperty
  property p_event_cause;
    $rose(lock_event) |-> $changed(lock_status);
  endproperty
  property p_lock_hold;
    s_pending(lock_event, ack_lock) |=> lock_event;
  endproperty
  property p_ref_hold;
    s_pending(ref_stop_event, ack_ref) |=> ref_stop_event;
  endproperty
  property p_ref_stop;
    $fell(ref_present) |-> ref_stop_event;
  endproperty
  property p_gap;
    $changed(lock_status) |-> since_r >= 5'd20;
  endproperty
  property p_idle;
    idle_r >= 5'd3 |-> $stable(lock_status);
  endproperty
  property p_gclk;
    gpio_clk |=> !gpio_clk;
  endproperty
  a_apply_only: assert property (p_apply_only) else $error("config moved without apply");
  a_fd_unsigned: assert property (p_fd_unsigned) else $error("fine fd decode wrong");
  a_lock_event: assert property (p_lock_event) else $error("lock change no event");
  a_event_cause: assert property (p_event_cause) else $error("lock event no cause");
  a_lock_hold: assert property (p_lock_hold) else $error("lock event lost");
  a_ref_hold: assert property (p_ref_hold) else $error("ref event lost");
  a_ref_stop: assert property (p_ref_stop) else $error("ref stop no event");
  a_gap: assert property (p_gap) else $error("lock not debounced");
  a_idle: assert property (p_idle) else $error("lock moved without clock");
  a_gclk: assert property (p_gclk) else $error("clock output stuck high");
endmodule // fll_checker
bind fll_cfg_status fll_checker u_chk (.mclk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
  .slow_clk_running, .system_clock_running, .ack_lock, .ack_ref, .phase_detector_fine_gain,
  .frequency_detector_fine_gain, .fd_fine_reserved, .loop_fraction_select,
  .oscillator_range_select, .lock_status, .ref_present, .lock_event, .ref_stop_event, .gpio_clk);

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic mclk, reset_n, reg_wr, reg_rd, slow_clk_running, system_clock_running;
  logic ack_lock, ack_ref, ref_run, ref_clk_level, loop_enable, fd_fine_reserved;
  logic loop_fraction_select, lock_status, ref_present, lock_event, ref_stop_event;
  logic gpio_lock, gpio_clk, c0;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, g, m;
  logic [7:0] phase_error;
  logic [3:0] thr;
  logic signed [4:0] pdf, pdc, fdf, fdc;
  logic [1:0] osc, ap_mode, ap_rng;
  logic [15:0] ap_gain;
  longint f_ref = 12000000;
  longint f_out = 49152000;
  longint f_osc, f_div, feedback_divider, integer_multiplier, gcd_a, gcd_b, gcd_t;
  longint fraction_numerator, fraction_denominator;
  logic host_frac;
  logic [15:0] mdl [int];
  int al[9] = '{'h191, 'h192, 'h196, 'h197, 'h198, 'h19A, 'h19B, 'h19D, 'h1A2};
  int n_mismatch = 0;
  int cmp_count = 0;
  fll_cfg_status dut (.mclk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .phase_error, .ref_clk_level, .slow_clk_running, .system_clock_running, .ack_lock,
    .ack_ref, .loop_enable, .phase_detector_fine_gain(pdf), .phase_detector_coarse_gain(pdc),
    .frequency_detector_fine_gain(fdf), .frequency_detector_coarse_gain(fdc),
    .fd_fine_reserved, .loop_fraction_select, .oscillator_range_select(osc), .lock_status,
    .ref_present, .lock_event, .ref_stop_event, .gpio_lock, .gpio_clk);
  ref_source src (.mclk, .run(ref_run), .ref_clk_level);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [15:0] exp_rd(input int a);
    case (a)
      'h191: return mdl[a] & 16'h0001;
      'h196: return mdl[a] & 16'h8000;
      'h198: return mdl[a];
      'h19A: return mdl[a] & 16'hC000;
      'h19B: return mdl[a] & 16'h001F;
      'h19D, 'h1A2: return mdl[a] & 16'h0003;
      default: return 16'h0000;
    endcase
  endfunction
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk) begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
    end
    @(posedge mclk) reg_wr <= 1'b0;
    if (mdl.exists(int'(a))) mdl[int'(a)] = d;
    // An apply with the loop stopped is dropped, so the model keeps the old set.
    if (a == 16'h0192 && d[15] && mdl['h191][0]) begin
      ap_gain = mdl['h198];
      ap_mode = mdl['h19A][15:14];
      ap_rng = mdl['h19D][1:0];
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge mclk) begin
      reg_addr <= a;
      reg_rd <= 1'b1;
    end
    @(posedge mclk) reg_rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), reg_rdata, e);
  endtask
  task automatic port_chk;
    repeat (3) @(posedge mclk);
    #1 chk("pd fine", {11'h0, pdf}, {11'h0, ap_gain[15], ap_gain[15:12]});
    chk("pd coarse", {11'h0, pdc}, {11'h0, ap_gain[11], ap_gain[11:8]});
    chk("fd fine", {11'h0, fdf}, {12'h0, ap_gain[7:4]});
    chk("fd coarse", {11'h0, fdc}, {11'h0, ap_gain[3], ap_gain[3:0]});
    chk("fd reserved", {15'h0, fd_fine_reserved}, {15'h0, ap_gain[7:4] == 4'hF});
    chk("mode", {15'h0, loop_fraction_select}, {15'h0, ap_mode == 2'h3});
    chk("range", {14'h0, osc}, {14'h0, ap_rng});
    chk("enable", {15'h0, loop_enable}, {15'h0, mdl['h191][0]});
  endtask
  task automatic wt(input int w, input logic v, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge mclk) #1;
      if ((w == 1 ? ref_present : lock_status) === v) return;
    end
    n_mismatch++;
    $display("BAD wait %0d expected %b", w, v);
    give_verdict();
  endtask
  task automatic ack(input int w);
    @(posedge mclk) if (w == 1) ack_ref <= 1'b1; else ack_lock <= 1'b1;
    @(posedge mclk) begin
      ack_ref <= 1'b0;
      ack_lock <= 1'b0;
    end
    repeat (2) @(posedge mclk);
    #1 chk("event cleared", {15'h0, w == 1 ? ref_stop_event : lock_event}, 16'h0);
  endtask
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, ack_lock, ack_ref, ref_run} = '0;
    {reset_n, slow_clk_running} = 2'b00;
    system_clock_running = 1'b1;
    phase_error = 8'hFF;
    void'($urandom(32'hBF38));
    mdl['h191] = 16'h0000;
    mdl['h196] = 16'h8000;
    mdl['h198] = 16'h21F0;
    mdl['h19A] = 16'h0000;
    mdl['h19B] = 16'h0011;
    mdl['h19D] = 16'h0000;
    mdl['h1A2] = 16'h0000;
    {ap_gain, ap_mode, ap_rng} = {16'h21F0, 2'h0, 2'h0};
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    port_chk();
    wr(16'h0197, 16'hFFFF);
    foreach (al[j]) rd(16'(al[j]), exp_rd(al[j]));
    // The host plans the last setting for a 12 MHz reference and a 49.152 MHz output.
    f_osc = (f_ref >= 1152000) ? 6 * f_out : f_out;
    feedback_divider = 1;
    f_div = feedback_divider * f_ref;
    integer_multiplier = f_osc / f_div;
    gcd_a = f_osc;
    gcd_b = f_div;
    for (int k = 0; k < 64 && gcd_b != 0; k++) begin
      gcd_t = gcd_a % gcd_b;
      gcd_a = gcd_b;
      gcd_b = gcd_t;
    end
    fraction_numerator = (f_osc - integer_multiplier * f_div) / gcd_a;
    fraction_denominator = f_div / gcd_a;
    host_frac = fraction_numerator != 0 && fraction_denominator > 1
                && integer_multiplier >= 4 && integer_multiplier <= 255;
    for (int i = 0; i < 8; i++) begin
      g = (i == 7) ? 16'h21F0 : 16'($urandom);
      m = (i == 7) ? {{2{host_frac}}, 14'h0000} : {i[1:0], 14'($urandom)};
      wr(16'h0198, g);
      wr(16'h019A, m);
      wr(16'h019D, (i == 7) ? 16'h0003 : 16'($urandom));
      if (i == 2) wr(16'h0191, 16'h0001);
      foreach (al[j]) rd(16'(al[j]), exp_rd(al[j]));
      wr(16'h0192, 16'h8000);
      port_chk();
    end
    thr = 4'($urandom_range(14, 0));
    wr(16'h019B, {11'h0, thr, 1'b1});
    wr(16'h01A2, 16'h0001);
    @(posedge mclk) phase_error <= {thr, 4'hF};
    wt(0, 1'b1, 60);
    chk("lock event", {15'h0, lock_event}, 16'h0001);
    chk("gpio lock", {15'h0, gpio_lock}, 16'h0001);
    rd(16'h01A0, 16'h0015);
    ack(0);
    @(posedge mclk) begin
      system_clock_running <= 1'b0;
      phase_error <= {thr, 4'hF} + 8'h01;
    end
    repeat (3) @(posedge mclk);
    #1 chk("gpio lock", {15'h0, gpio_lock}, 16'h0000);
    rd(16'h01A0, 16'h0001);
    repeat (60) @(posedge mclk);
    #1 chk("held lock", {15'h0, lock_status}, 16'h0001);
    @(posedge mclk) slow_clk_running <= 1'b1;
    wt(0, 1'b0, 60);
    chk("lock event", {15'h0, lock_event}, 16'h0001);
    ack(0);
    wr(16'h019B, {11'h0, thr, 1'b0});
    @(posedge mclk) phase_error <= 8'h00;
    repeat (60) @(posedge mclk);
    rd(16'h01A0, 16'h0000);
    wr(16'h019B, 16'h001F);
    port_chk();
    @(posedge mclk) ref_run <= 1'b1;
    wt(1, 1'b1, 200);
    @(posedge mclk) ref_run <= 1'b0;
    wt(1, 1'b0, 600);
    chk("ref stop", {15'h0, ref_stop_event}, 16'h0001);
    ack(1);
    wr(16'h0196, 16'h0000);
    @(posedge mclk) ref_run <= 1'b1;
    repeat (100) @(posedge mclk);
    #1 chk("ref off", {15'h0, ref_present}, 16'h0000);
    wr(16'h01A2, 16'h0002);
    repeat (2) @(posedge mclk);
    #1 c0 = gpio_clk;
    @(posedge mclk) #1 chk("gpio clk", {15'h0, gpio_clk}, {15'h0, ~c0});
    give_verdict();
  end
endmodule // tb
